// file: rtl/cal_map.vh
// constants for the quad channel calibration block
`ifndef CAL_MAP_VH
`define CAL_MAP_VH

// ****************************************
// widths
// ****************************************
`define CODE_W        16
`define GAIN_W        8
`define ZERO_W        9
`define OUT_W         19
`define SUM_W         21
`define PROD_W        29
`define NUM_CH        4

// ****************************************
// serial frame layout
// ****************************************
`define FRAME_BITS    5'h18
`define CNT_W         5
`define CNT_MAX       5'h1F
`define SEL_MSB       23
`define SEL_LSB       20
`define DATA_MSB      15
`define SHIFT_W       24
`define TGT_MSB       3
`define TGT_LSB       2
`define CH_MSB        1
`define GRP_SIZE      2

// ****************************************
// target selector codes (upper nibble of frame)
// ****************************************
`define SEL_GAIN      2'h0
`define SEL_ZERO      2'h1
`define SEL_INPUT     2'h2

// ****************************************
// reset values and scaling
// ****************************************
`define GAIN_RST      8'h00
`define ZERO_RST      9'h000
`define CODE_RST      16'h0000
`define OUT_RST       19'h00000
`define SHIFT_RST     24'h000000
`define CNT_RST       5'h00
`define CNT_STEP      5'h01
`define SYNC_RST      5'h03
`define OUT_UNI_MAX   19'h7FFFF
`define OUT_BIP_MAX   19'h3FFFF
`define OUT_BIP_MIN   19'h40000
`define FRAC_BITS     3
`define UNI_SHIFT     16
`define BIP_SHIFT     17
`define UNI_MAX       22'h07FFFF
`define BIP_MAX       22'h03FFFF
`define BIP_MIN       22'h3C0000

`endif

// file: rtl/cal_datapath.v
// per-channel gain and zero correction arithmetic
`include "cal_map.vh"

module cal_datapath (
   code,
   gain,
   zero,
   bipolar,
   result
);
   input  wire [`CODE_W-1:0] code;
   input  wire [`GAIN_W-1:0] gain;
   input  wire [`ZERO_W-1:0] zero;
   input  wire               bipolar;
   output reg  [`OUT_W-1:0]  result;

   wire signed [`SUM_W-1:0]  code_ext;
   wire signed [`SUM_W-1:0]  zero_ext;
   wire signed [`SUM_W-1:0]  sum8;
   wire signed [`PROD_W-1:0] prod;
   wire signed [`PROD_W-1:0] prod_sh;
   wire signed [`SUM_W:0]    corr;

   // input code in eighths of an lsb, sign by group mode
   assign code_ext = bipolar ? {{2{code[`CODE_W-1]}}, code, {`FRAC_BITS{1'b0}}}
                             : {2'b00, code, {`FRAC_BITS{1'b0}}};
   assign zero_ext = {{(`SUM_W-`ZERO_W){zero[`ZERO_W-1]}}, zero};
   assign sum8     = code_ext + zero_ext;
   // operands widened to product width, sign kept
   assign prod     = $signed({{(`PROD_W-`SUM_W){sum8[`SUM_W-1]}}, sum8})
                   * $signed({{(`PROD_W-`GAIN_W){gain[`GAIN_W-1]}}, gain});
   // gain fraction halved in bipolar mode
   assign prod_sh  = bipolar ? (prod >>> `BIP_SHIFT) : (prod >>> `UNI_SHIFT);
   assign corr     = {sum8[`SUM_W-1], sum8} + prod_sh[`SUM_W:0];

   // saturate to the mode's code range
   always @* begin
      if (bipolar) begin
         if (corr > $signed(`BIP_MAX))
            result = `OUT_BIP_MAX;
         else if (corr < $signed(`BIP_MIN))
            result = `OUT_BIP_MIN;
         else
            result = corr[`OUT_W-1:0];
      end else begin
         if (corr[`SUM_W])
            result = `OUT_RST;
         else if (corr > $signed(`UNI_MAX))
            result = `OUT_UNI_MAX;
         else
            result = corr[`OUT_W-1:0];
      end
   end
endmodule

// file: rtl/quad_dac_channel_calibration.v
// serial write port, trim storage and corrected codes for four channels
`include "cal_map.vh"

module quad_dac_channel_calibration (
   core_clk,
   nrst,
   sclk,
   cs_n,
   sdi,
   group_one_polarity_select,
   group_two_polarity_select,
   cal_code,
   frame_done
);
   input  wire                       core_clk;
   input  wire                       nrst;
   input  wire                       sclk;
   input  wire                       cs_n;
   input  wire                       sdi;
   input  wire                       group_one_polarity_select;
   input  wire                       group_two_polarity_select;
   output wire [`NUM_CH*`OUT_W-1:0]  cal_code;
   output reg                        frame_done;

   // ****************************************
   // pin synchronisers
   // ****************************************
   reg  [4:0]            sync1_reg;
   reg  [4:0]            sync2_reg;
   reg                   sclk_prev_reg;
   reg                   cs_prev_reg;
   wire                  sclk_s;
   wire                  cs_s;
   wire                  sdi_s;
   wire                  pol_one_s;
   wire                  pol_two_s;

   // two stages on every pin
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sync1_reg <= `SYNC_RST;
         sync2_reg <= `SYNC_RST;
      end else begin
         sync1_reg <= {group_two_polarity_select, group_one_polarity_select,
                       sdi, cs_n, sclk};
         sync2_reg <= sync1_reg;
      end
   end

   // edge history, reset to the idle high levels
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sclk_prev_reg <= 1'b1;
         cs_prev_reg   <= 1'b1;
      end else begin
         sclk_prev_reg <= sclk_s;
         cs_prev_reg   <= cs_s;
      end
   end

   assign sclk_s    = sync2_reg[0];
   assign cs_s      = sync2_reg[1];
   assign sdi_s     = sync2_reg[2];
   assign pol_one_s = sync2_reg[3];
   assign pol_two_s = sync2_reg[4];

   // ****************************************
   // serial frame receiver
   // ****************************************
   // frame shift register and bit count
   reg  [`SHIFT_W-1:0]   shift_reg;
   reg  [`CNT_W-1:0]     count_reg;
   wire [`CNT_W-1:0]     count_next;
   wire                  sclk_fall;
   wire                  cs_rise;
   wire                  commit;

   // data taken on falling sclk edges inside a frame
   assign sclk_fall = sclk_prev_reg & ~sclk_s & ~cs_s;
   assign cs_rise   = cs_s & ~cs_prev_reg;
   // word only counts with exactly the full number of bits
   assign commit    = cs_rise & (count_reg == `FRAME_BITS);

   // count saturates so long frames stay rejected
   assign count_next = (count_reg == `CNT_MAX) ? count_reg : count_reg + `CNT_STEP;

   // shift in bits msb first, select high clears the count
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         shift_reg <= `SHIFT_RST;
         count_reg <= `CNT_RST;
      end else if (cs_s) begin
         count_reg <= `CNT_RST;
      end else if (sclk_fall) begin
         shift_reg <= {shift_reg[`SHIFT_W-2:0], sdi_s};
         count_reg <= count_next;
      end
   end

   // ****************************************
   // frame decode
   // ****************************************
   // decoded fields and write strobes
   wire [3:0]            sel;
   wire [1:0]            target;
   wire [1:0]            ch_idx;
   wire                  wr_gain;
   wire                  wr_zero;
   wire                  wr_code;
   wire                  accept;

   // upper nibble picks target and channel
   assign sel     = shift_reg[`SEL_MSB:`SEL_LSB];
   assign target  = sel[`TGT_MSB:`TGT_LSB];
   assign ch_idx  = sel[`CH_MSB:0];

   // one strobe per target, unused target code drops the frame
   assign wr_gain = commit & (target == `SEL_GAIN);
   assign wr_zero = commit & (target == `SEL_ZERO);
   assign wr_code = commit & (target == `SEL_INPUT);
   assign accept  = wr_gain | wr_zero | wr_code;

   // one-cycle pulse for each accepted frame
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst)
         frame_done <= 1'b0;
      else
         frame_done <= accept;
   end

   // ****************************************
   // group polarity
   // ****************************************
   wire                  bip_one;
   wire                  bip_two;

   // low pin puts channels zero and one in bipolar mode
   assign bip_one = ~pol_one_s;

   // low pin puts channels two and three in bipolar mode
   assign bip_two = ~pol_two_s;

   // ****************************************
   // per-channel storage and correction
   // ****************************************
   genvar i;
   generate
      for (i = 0; i < `NUM_CH; i = i + 1) begin : chan
         // trims, input code and registered output of this channel
         reg  [`GAIN_W-1:0] gain_reg;
         reg  [`ZERO_W-1:0] zero_reg;
         reg  [`CODE_W-1:0] code_reg;
         reg  [`OUT_W-1:0]  out_reg;
         wire [`OUT_W-1:0]  corr_next;
         wire               hit;
         wire               bipolar;

         // this channel addressed by the frame
         assign hit = (ch_idx == i);
         assign bipolar = (i < `GRP_SIZE) ? bip_one : bip_two;

         always @(posedge core_clk or negedge nrst) begin
            if (!nrst)
               gain_reg <= `GAIN_RST;
            else if (wr_gain & hit)
               gain_reg <= shift_reg[`GAIN_W-1:0];
         end

         always @(posedge core_clk or negedge nrst) begin
            if (!nrst)
               zero_reg <= `ZERO_RST;
            else if (wr_zero & hit)
               zero_reg <= shift_reg[`ZERO_W-1:0];
         end

         // input code register, cleared by reset
         always @(posedge core_clk or negedge nrst) begin
            if (!nrst)
               code_reg <= `CODE_RST;
            else if (wr_code & hit)
               code_reg <= shift_reg[`DATA_MSB:0];
         end

         cal_datapath u_dp (
            .code    (code_reg),
            .gain    (gain_reg),
            .zero    (zero_reg),
            .bipolar (bipolar),
            .result  (corr_next)
         );

         // registered corrected code to the ladder
         always @(posedge core_clk or negedge nrst) begin
            if (!nrst)
               out_reg <= `OUT_RST;
            else
               out_reg <= corr_next;
         end

         // pack this channel onto the output bus
         assign cal_code[i*`OUT_W +: `OUT_W] = out_reg;
      end
   endgenerate
endmodule

// file: verification/host_spi.sv
// host serial master model driving frames into the block
module host_spi (
   output logic sclk,
   output logic cs_n,
   output logic sdi
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      sdi  = 1'b0;
   end
   // one frame of n bits, msb first, clock idles high
   task automatic xfer(input logic [23:0] w, input int n);
      cs_n = 1'b0;
      #40;
      for (int i = 0; i < n; i++) begin
         sdi = (i < 24) ? w[23-i] : 1'b0; // bits past the word are zero
         #40;
         sclk = 1'b0;
         #80;
         sclk = 1'b1;
         #40;
      end
      cs_n = 1'b1;
      sdi  = ~sdi; // released line shows no stale bit
      #60;
   endtask
endmodule

// file: verification/quad_cal_chk.sv
// port assertions for the calibration block
`include "cal_map.vh"
module quad_cal_chk (
   input logic                          core_clk,
   input logic                          nrst,
   input logic                          sclk,
   input logic                          cs_n,
   input logic                          sdi,
   input logic                          group_one_polarity_select,
   input logic                          group_two_polarity_select,
   input logic [`NUM_CH*`OUT_W-1:0]     cal_code,
   input logic                          frame_done
);
   timeunit 1ns;
   timeprecision 100ps;
   reg [2:0] sk_reg;
   reg       cs_reg;
   reg [4:0] nb_reg;
   // counts synced serial falls since select fell
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sk_reg <= 3'h7;
         cs_reg <= 1'b1;
         nb_reg <= 5'h00;
      end else begin
         sk_reg <= {sk_reg[1:0], sclk};
         cs_reg <= cs_n;
         if (cs_reg && !cs_n) nb_reg <= 5'h00;
         else if (sk_reg[2] && !sk_reg[1] && nb_reg != `CNT_MAX) nb_reg <= nb_reg + 5'h01;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   sequence s_quiet; !frame_done [*8]; endsequence
   property p_pulse; frame_done |=> s_quiet; endproperty
   property p_after_cs; frame_done |-> $past(cs_n, 2); endproperty
   property p_count; frame_done |-> nb_reg == `FRAME_BITS; endproperty
   property p_cs_low; !cs_n && !$past(cs_n, 4) |-> !frame_done; endproperty
   // output register follows the done pulse by one cycle
   property p_grp1; !$stable(cal_code[37:0]) |-> $past(frame_done) ||
      $past(group_one_polarity_select, 2) != $past(group_one_polarity_select, 5); endproperty
   property p_grp2; !$stable(cal_code[75:38]) |-> $past(frame_done) ||
      $past(group_two_polarity_select, 2) != $past(group_two_polarity_select, 5); endproperty
   property p_rst_zero; $rose(nrst) |-> cal_code == '0; endproperty
   property p_rst_quiet; $rose(nrst) |-> s_quiet; endproperty
   a_pulse: assert property (p_pulse) else $error("done pulse too long");
   a_after_cs: assert property (p_after_cs) else $error("done without select high");
   a_count: assert property (p_count) else $error("done without 24 bits");
   a_cs_low: assert property (p_cs_low) else $error("done inside frame");
   a_grp1: assert property (p_grp1) else $error("group one changed alone");
   a_grp2: assert property (p_grp2) else $error("group two changed alone");
   a_rst_zero: assert property (p_rst_zero) else $error("code not zero at reset");
   a_rst_quiet: assert property (p_rst_quiet) else $error("done after reset");
endmodule

// file: verification/quad_dac_channel_calibration_tb_top.sv
// testbench for the calibration block
`include "cal_map.vh"
module quad_dac_channel_calibration_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic                      core_clk = 1'b0;
   logic                      nrst = 1'b0;
   logic                      sclk, cs_n, sdi, frame_done;
   logic                      group_one_polarity_select = 1'b1;
   logic                      group_two_polarity_select = 1'b0;
   logic [`NUM_CH*`OUT_W-1:0] cal_code;
   logic [15:0]               c_m [4] = '{default: 16'h0000};
   logic [7:0]                g_m [4] = '{default: 8'h00};
   logic [8:0]                z_m [4] = '{default: 9'h000};
   int                        bad_count = 0, n_checks = 0, n_done = 0;
   host_spi i_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi));
   quad_dac_channel_calibration i_quad_dac_channel_calibration (.core_clk(core_clk),
      .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .cal_code(cal_code),
      .group_one_polarity_select(group_one_polarity_select), .frame_done(frame_done),
      .group_two_polarity_select(group_two_polarity_select));
   always #2.5 core_clk = ~core_clk;
   // done pulse sampled mid-cycle, well away from its launching edge
   always @(negedge core_clk) if (frame_done === 1'b1) n_done++;
   task chk(input logic [75:0] got, input logic [75:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   function automatic longint ex(logic [15:0] c, logic [7:0] g, logic [8:0] z, bit bp);
      longint x, y;
      x = (bp ? longint'($signed(c)) : longint'(c)) * 8 + longint'($signed(z));
      y = x + ((x * longint'($signed(g))) >>> (bp ? 17 : 16));
      if (bp) y = y > 262143 ? 262143 : (y < -262144 ? -262144 : y);
      else y = y > 524287 ? 524287 : (y < 0 ? 0 : y);
      return y;
   endfunction
   task send(input logic [23:0] w, input int n, input int want);
      int d;
      d = n_done;
      i_host.xfer(w, n);
      repeat (10) @(negedge core_clk);
      chk(n_done - d, want);
   endtask
   task recheck;
      longint e;
      for (int ch = 0; ch < 4; ch++) begin
         e = ex(c_m[ch], g_m[ch], z_m[ch],
                ch < 2 ? !group_one_polarity_select : !group_two_polarity_select);
         chk(cal_code[ch*`OUT_W +: `OUT_W], e[18:0]);
      end
   endtask
   task cal(input int ch, input logic [15:0] c, input logic [7:0] g, input logic [8:0] z);
      send({2'h0, ch[1:0], 12'h000, g}, 24, 1);
      send({2'h1, ch[1:0], 11'h000, z}, 24, 1);
      send({2'h2, ch[1:0], 4'h0, c}, 24, 1);
      c_m[ch] = c;
      g_m[ch] = g;
      z_m[ch] = z;
      recheck;
   endtask
   task t_trim;
      cal(0, 16'hFFFF, 8'h7F, 9'h0FF);
      cal(1, 16'h8000, 8'h80, 9'h100);
      cal(2, 16'h8000, 8'h80, 9'h100);
      cal(3, 16'h1234, 8'h05, 9'h1F8);
      $display("trim test done");
   endtask
   task t_refuse;
      send({2'h2, 2'h0, 4'h0, 16'h5555}, 23, 0);
      send({2'h2, 2'h0, 4'h0, 16'h5555}, 25, 0);
      send({2'h3, 2'h1, 4'h0, 16'h00AA}, 24, 0);
      recheck;
      $display("refuse test done");
   endtask
   task t_pol;
      group_one_polarity_select = 1'b0;
      group_two_polarity_select = 1'b1;
      repeat (10) @(negedge core_clk);
      recheck;
      $display("polarity test done");
   endtask
   task t_rerst;
      cal(2, 16'h0100, 8'h10, 9'h010);
      nrst = 1'b0;
      repeat (12) @(negedge core_clk);
      nrst = 1'b1;
      c_m = '{default: 16'h0000};
      g_m = '{default: 8'h00};
      z_m = '{default: 9'h000};
      repeat (3) @(negedge core_clk);
      recheck;
      send({2'h2, 2'h2, 4'h0, 16'h0100}, 24, 1);
      c_m[2] = 16'h0100;
      recheck;
      $display("second reset test done");
   endtask
   initial begin
      repeat (12) @(negedge core_clk);
      nrst = 1'b1;
      repeat (3) @(negedge core_clk);
      recheck;
      $display("reset test done");
      t_trim;
      t_refuse;
      t_pol;
      t_rerst;
      print_verdict;
   end
   initial begin
      #400000;
      bad_count++;
      print_verdict;
   end
endmodule
bind quad_dac_channel_calibration quad_cal_chk i_quad_cal_chk (.core_clk(core_clk),
   .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .cal_code(cal_code),
   .group_one_polarity_select(group_one_polarity_select), .frame_done(frame_done),
   .group_two_polarity_select(group_two_polarity_select));
